// [pkg/spcq_pkg.sv]
package spcq_pkg;

    // ----------------------------------------------------------------------
    // Queue geometry
    // ----------------------------------------------------------------------
    localparam int unsigned PAGE_BYTES      = 4096;
    localparam int unsigned DESC_BYTES      = 64;
    localparam int unsigned SLOTS           = PAGE_BYTES / DESC_BYTES;
    localparam int unsigned IDX_W           = 16;
    localparam int unsigned MAX_QUEUED      = 8;
    localparam int unsigned CTX_ALIGN_BYTES = 4096;
    localparam int unsigned RX_ALIGN_BYTES  = 16;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [15:0] PROD_RESET      = 16'h0000;
    localparam logic [15:0] CID_LEADING     = 16'h0000;
    localparam logic [7:0]  SB_IDX_RESET    = 8'h00;

    // ----------------------------------------------------------------------
    // Interrupt vector limits
    // ----------------------------------------------------------------------
    localparam logic [4:0]  MSI_MAX_VECTORS  = 5'h04;
    localparam logic [4:0]  MSIX_MAX_VECTORS = 5'h10;

    // ----------------------------------------------------------------------
    // Management mailbox word layout
    // ----------------------------------------------------------------------
    localparam int unsigned MBOX_CMD_LSB    = 16;
    localparam int unsigned MBOX_SEQ_LSB    = 0;

    // ----------------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_PORT_SETUP   = 4'h1,
        CMD_CLIENT_SETUP = 4'h2,
        CMD_STAT_QUERY   = 4'h3,
        CMD_UPDATE       = 4'h4,
        CMD_HALT         = 4'h5,
        CMD_ADDRESS_SET  = 4'h6,
        CMD_CTX_DELETE   = 4'h7,
        CMD_PORT_DELETE  = 4'h8,
        CMD_FORWARD      = 4'h9
    } spcq_cmd_type;

    // ----------------------------------------------------------------------
    // Unload outcomes
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        UNLOAD_NONE     = 2'b00,
        UNLOAD_COMMON   = 2'b01,
        UNLOAD_PORT     = 2'b10,
        UNLOAD_FUNCTION = 2'b11
    } spcq_unload_type;

    typedef enum logic [1:0] {
        IRQ_LINE = 2'b00,
        IRQ_MSI  = 2'b01,
        IRQ_MSIX = 2'b10
    } spcq_irq_type;

endpackage

// [src/spcq_slow_path.sv]
// Overview of operation
// - Producer index write triggers command fetch
// - One completion entry, no buffer descriptor
// - Port setup initializes leading connection zero
// - Port setup completes on leading queue
// - Statistics query bumps status index
// - Port delete bumps status index
// - Client setup completes on its connection
// - Halt completes on own connection, refused on leading
// - Update completes on leading queue
// - Address set completes on leading queue
// - Context delete completes on leading queue
// - Forwarding setup completes on offloaded connection
// - Unload answered common, port or function
// - Line, 4 message, 16 extended vectors
`timescale 1ns/1ps
`default_nettype none

module spcq_slow_path #(
    parameter int unsigned SLOTS = spcq_pkg::SLOTS
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // Queue setup writes into processor memory
    input  wire logic        PAGE_BASE_WR,
    input  wire logic [63:0] PAGE_BASE_DATA,
    input  wire logic        PROD_WR,
    input  wire logic [15:0] PROD_DATA,
    // Descriptor fetched at the consumer slot
    output logic             FETCH_REQ,
    output logic [63:0]      FETCH_ADDR,
    input  wire logic        FETCH_VALID,
    input  wire logic [3:0]  FETCH_CMD,
    input  wire logic [15:0] FETCH_CID,
    // Completion entry posting
    output logic             CQE_VALID,
    output logic [15:0]      CQE_CID,
    output logic [3:0]       CQE_CMD,
    output logic             CQE_SLOW_PATH,
    output logic             CQE_ERROR,
    output logic             BD_CONSUME,
    // Default status block index
    output logic [7:0]       SB_COMPLETION_IDX,
    // Port state
    output logic             PORT_READY,
    output logic             LEAD_LOCKED,
    output logic             PROC_INIT,
    output logic [15:0]      CONS_IDX,
    // Management mailbox
    input  wire logic        LOAD_DONE,
    input  wire logic        MBOX_WR,
    input  wire logic [31:0] MBOX_DATA,
    output logic             MBOX_RESP_VALID,
    output logic [31:0]      MBOX_RESP,
    input  wire logic [1:0]  UNLOAD_KIND,
    // Interrupt capabilities
    output logic [4:0]       MSI_VECTORS,
    output logic [4:0]       MSIX_VECTORS,
    output logic             LINE_IRQ_SUPPORTED
);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b10
    } spcq_state_type;

    spcq_state_type  state_q;
    logic [63:0]     base_q;
    logic [15:0]     prod_q;
    logic [15:0]     cons_q;
    logic            ready_q;
    logic            loaded_q;
    logic            locked_q;
    logic            pinit_q;
    logic [3:0]      cmd_q;
    logic [15:0]     cid_q;
    logic            cqe_v_q;
    logic [15:0]     cqe_cid_q;
    logic [3:0]      cqe_cmd_q;
    logic            cqe_err_q;
    logic [7:0]      sb_q;
    logic            mb_v_q;
    logic [31:0]     mb_q;
    logic [15:0]     cons_d;

    // ----------------------------------------------------------------------
    // Index arithmetic
    // ----------------------------------------------------------------------
    // Same modulo as the host so a wrapped index never looks empty
    // Slot count must divide the page; no partial descriptors
    assign cons_d = (cons_q == 16'(SLOTS - 1)) ? 16'h0000
                                              : cons_q + 16'h0001;

    // ----------------------------------------------------------------------
    // Queue setup
    // ----------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            base_q <= 64'h0;
            prod_q <= spcq_pkg::PROD_RESET;
        end else begin
            if (PAGE_BASE_WR) begin
                base_q <= PAGE_BASE_DATA;
            end
            // A write mid-command is seen once back in idle
            if (PROD_WR) begin
                prod_q <= PROD_DATA;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Load handshake
    // ----------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            loaded_q <= 1'b0;
        // Sticky: the message is sent once per reset
        end else if (LOAD_DONE) begin
            loaded_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------------
    // One command in flight; the host paces the rest
    // Limitation: a descriptor that never arrives stalls the queue
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            cons_q  <= spcq_pkg::PROD_RESET;
            cmd_q   <= 4'h0;
            cid_q   <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cons_q != prod_q) begin
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (FETCH_VALID) begin
                        cmd_q   <= FETCH_CMD;
                        cid_q   <= FETCH_CID;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    cons_q  <= cons_d;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Port state
    // ----------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ready_q  <= 1'b0;
            locked_q <= 1'b0;
            pinit_q  <= 1'b0;
        end else if (state_q == ST_EXEC) begin
            if (cmd_q == spcq_pkg::CMD_PORT_SETUP && loaded_q
                && !ready_q) begin
                ready_q  <= 1'b1;
                locked_q <= 1'b1;
                pinit_q  <= 1'b1;
            end else if (cmd_q == spcq_pkg::CMD_PORT_DELETE && ready_q) begin
                // Processors stay set up until the next reset
                ready_q  <= 1'b0;
                locked_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Completion routing
    // ----------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cqe_v_q   <= 1'b0;
            cqe_cid_q <= 16'h0000;
            cqe_cmd_q <= 4'h0;
            cqe_err_q <= 1'b0;
            sb_q      <= spcq_pkg::SB_IDX_RESET;
        end else begin
            // CID holds until the next completion; command and error fields update on every executed command
            cqe_v_q <= 1'b0;
            if (state_q == ST_EXEC) begin
                cqe_cmd_q <= cmd_q;
                cqe_err_q <= 1'b0;
                case (cmd_q)
                    spcq_pkg::CMD_PORT_SETUP: begin
                        cqe_v_q   <= 1'b1;
                        cqe_cid_q <= spcq_pkg::CID_LEADING;
                        // Setup before load, or a repeat, is flagged failed
                        cqe_err_q <= !loaded_q || ready_q;
                    end
                    spcq_pkg::CMD_STAT_QUERY,
                    spcq_pkg::CMD_PORT_DELETE: begin
                        if (ready_q) begin
                            sb_q <= sb_q + 8'h01;
                        end else begin
                            // No port yet: refuse through the leading queue
                            cqe_v_q   <= 1'b1;
                            cqe_cid_q <= spcq_pkg::CID_LEADING;
                            cqe_err_q <= 1'b1;
                        end
                    end
                    spcq_pkg::CMD_CLIENT_SETUP,
                    spcq_pkg::CMD_FORWARD: begin
                        cqe_v_q   <= 1'b1;
                        cqe_cid_q <= cid_q;
                        cqe_err_q <= !ready_q;
                    end
                    spcq_pkg::CMD_HALT: begin
                        cqe_v_q   <= 1'b1;
                        cqe_cid_q <= cid_q;
                        // Halting the leading connection is refused
                        cqe_err_q <= !ready_q
                                     || cid_q == spcq_pkg::CID_LEADING;
                    end
                    spcq_pkg::CMD_UPDATE,
                    spcq_pkg::CMD_ADDRESS_SET,
                    spcq_pkg::CMD_CTX_DELETE: begin
                        cqe_v_q   <= 1'b1;
                        cqe_cid_q <= spcq_pkg::CID_LEADING;
                        cqe_err_q <= !ready_q;
                    end
                    default: begin
                        cqe_v_q   <= 1'b1;
                        cqe_cid_q <= spcq_pkg::CID_LEADING;
                        cqe_err_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------------
    // Management mailbox
    // ----------------------------------------------------------------------
    // Answer echoes the sequence; unload carries the chosen outcome
    // Response is one cycle late, so the host must wait for it
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            mb_v_q <= 1'b0;
            mb_q   <= 32'h0;
        end else begin
            mb_v_q <= MBOX_WR;
            if (MBOX_WR) begin
                mb_q <= {MBOX_DATA[31:spcq_pkg::MBOX_CMD_LSB+2],
                         UNLOAD_KIND,
                         MBOX_DATA[spcq_pkg::MBOX_CMD_LSB-1:
                                   spcq_pkg::MBOX_SEQ_LSB]};
            end
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign FETCH_REQ          = (state_q == ST_FETCH);
    assign FETCH_ADDR         = base_q
                                + 64'(cons_q) * 64'(spcq_pkg::DESC_BYTES);
    assign CQE_VALID          = cqe_v_q;
    assign CQE_CID            = cqe_cid_q;
    assign CQE_CMD            = cqe_cmd_q;
    assign CQE_SLOW_PATH      = cqe_v_q;
    assign CQE_ERROR          = cqe_err_q;
    assign BD_CONSUME         = 1'b0;
    assign SB_COMPLETION_IDX  = sb_q;
    assign PORT_READY         = ready_q;
    assign LEAD_LOCKED        = locked_q;
    assign PROC_INIT          = pinit_q;
    assign CONS_IDX           = cons_q;
    assign MBOX_RESP_VALID    = mb_v_q;
    assign MBOX_RESP          = mb_q;
    // Capabilities are fixed; software only reads them
    assign MSI_VECTORS        = spcq_pkg::MSI_MAX_VECTORS;
    assign MSIX_VECTORS       = spcq_pkg::MSIX_MAX_VECTORS;
    assign LINE_IRQ_SUPPORTED = 1'b1;

endmodule

`default_nettype wire

// [verification/spcq_chk.sv]
`timescale 1ns/1ps
`default_nettype none

module spcq_chk #(
    parameter int unsigned SLOTS = spcq_pkg::SLOTS
) (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESET,
    // Fetch and completion
    input wire logic        FETCH_REQ,
    input wire logic        FETCH_VALID,
    input wire logic [3:0]  FETCH_CMD,
    input wire logic [15:0] FETCH_CID,
    input wire logic        CQE_VALID,
    input wire logic [15:0] CQE_CID,
    input wire logic [3:0]  CQE_CMD,
    input wire logic        CQE_SLOW_PATH,
    input wire logic        CQE_ERROR,
    input wire logic        BD_CONSUME,
    input wire logic [7:0]  SB_COMPLETION_IDX,
    input wire logic        PORT_READY,
    input wire logic [15:0] CONS_IDX,
    // Mailbox
    input wire logic        MBOX_WR,
    input wire logic [31:0] MBOX_DATA,
    input wire logic        MBOX_RESP_VALID,
    input wire logic [31:0] MBOX_RESP,
    input wire logic [1:0]  UNLOAD_KIND
);
    localparam logic [15:0] LAST = 16'(SLOTS - 1);

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // ----
    // Steps
    // ----
    sequence taken;
        FETCH_VALID && FETCH_REQ;
    endsequence

    sequence posted_on(logic [15:0] id);
        CQE_VALID && !CQE_ERROR && CQE_CID == id;
    endsequence

    slow_flag_a: assert property (CQE_SLOW_PATH == CQE_VALID
        && !BD_CONSUME)
        else $error("completion flag or buffer use wrong");
    one_entry_a: assert property (CQE_VALID |=> !CQE_VALID)
        else $error("completion entry stood too long");
    idx_wrap_a: assert property (CQE_VALID |-> CONS_IDX ==
        (($past(CONS_IDX) == LAST) ? 16'h0000 : $past(CONS_IDX) + 16'h0001))
        else $error("consumer index did not step");
    setup_lead_a: assert property (taken ##0 FETCH_CMD == 4'h1 |-> ##2
        CQE_VALID && (CQE_ERROR || (PORT_READY && CQE_CMD == 4'h1
        && CQE_CID == 16'h0000)))
        else $error("port setup completion wrong");
    early_err_a: assert property (taken ##0 !PORT_READY
        && FETCH_CMD != 4'h1 |-> ##2 CQE_VALID && CQE_ERROR)
        else $error("command before setup not refused");
    sb_bump_a: assert property (taken ##0 PORT_READY &&
        (FETCH_CMD == 4'h3 || FETCH_CMD == 4'h8) |-> ##2 !CQE_VALID
        && SB_COMPLETION_IDX == $past(SB_COMPLETION_IDX, 2) + 8'h01)
        else $error("status index not bumped");
    lead_q_a: assert property (taken ##0 PORT_READY
        && FETCH_CMD inside {4'h4, 4'h6, 4'h7} |-> ##2 posted_on(16'h0000))
        else $error("leading queue completion missing");
    own_q_a: assert property (taken ##0 PORT_READY
        && (FETCH_CMD inside {4'h2, 4'h9}
        || (FETCH_CMD == 4'h5 && FETCH_CID != 16'h0000))
        |-> ##2 posted_on($past(FETCH_CID, 2)))
        else $error("own queue completion missing");
    halt_lead_a: assert property (taken ##0 FETCH_CMD == 4'h5
        && FETCH_CID == 16'h0000 |-> ##2 CQE_VALID && CQE_ERROR)
        else $error("halt on leading not refused");
    mbox_echo_a: assert property (MBOX_WR |=> MBOX_RESP_VALID &&
        MBOX_RESP == {$past(MBOX_DATA[31:18]), $past(UNLOAD_KIND),
        $past(MBOX_DATA[15:0])})
        else $error("mailbox answer wrong");
endmodule

bind spcq_slow_path spcq_chk #(.SLOTS(SLOTS)) u_chk (
    .REF_CLK(REF_CLK), .RESET(RESET), .FETCH_REQ(FETCH_REQ),
    .FETCH_VALID(FETCH_VALID), .FETCH_CMD(FETCH_CMD),
    .FETCH_CID(FETCH_CID), .CQE_VALID(CQE_VALID), .CQE_CID(CQE_CID),
    .CQE_CMD(CQE_CMD), .CQE_SLOW_PATH(CQE_SLOW_PATH),
    .CQE_ERROR(CQE_ERROR), .BD_CONSUME(BD_CONSUME),
    .SB_COMPLETION_IDX(SB_COMPLETION_IDX), .PORT_READY(PORT_READY),
    .CONS_IDX(CONS_IDX), .MBOX_WR(MBOX_WR), .MBOX_DATA(MBOX_DATA),
    .MBOX_RESP_VALID(MBOX_RESP_VALID), .MBOX_RESP(MBOX_RESP),
    .UNLOAD_KIND(UNLOAD_KIND)
);

`default_nettype wire

// [verification/spcq_host_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module spcq_host_mem (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Device fetch side
    input  wire logic        req,
    output logic             valid,
    output logic [3:0]       cmd,
    output logic [15:0]      cid,
    // Descriptor filled by the host, answer lag
    input  wire logic [3:0]  cmd_in,
    input  wire logic [15:0] cid_in,
    input  wire logic [1:0]  lag
);
    logic [1:0] wait_q;
    logic       done_q;

    always_ff @(posedge clk) begin
        if (rst || !req) begin
            wait_q <= 2'h0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            wait_q <= wait_q + 2'h1;
            done_q <= (wait_q == lag);
        end
    end

    // Idle lines toggle so stale data never passes for an answer
    always_ff @(posedge clk) begin
        if (rst) begin
            valid <= 1'b0;
            cmd   <= 4'h0;
            cid   <= 16'h0000;
        end else if (req && !done_q && wait_q == lag) begin
            valid <= 1'b1;
            cmd   <= cmd_in;
            cid   <= cid_in;
        end else begin
            valid <= 1'b0;
            cmd   <= ~cmd;
            cid   <= ~cid;
        end
    end
endmodule

`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk, reset, base_wr, prod_wr, load_done, mbox_wr;
    logic        f_req, f_valid, cqe_valid, cqe_slow, cqe_err, bd;
    logic        ready, locked, proc_init, resp_valid, line_irq;
    logic [1:0]  unload, lag;
    logic [3:0]  f_cmd, cqe_cmd, h_cmd;
    logic [4:0]  msi, msix;
    logic [7:0]  sb;
    logic [15:0] prod, f_cid, cqe_cid, cons, h_cid;
    logic [31:0] mbox_data, resp;
    logic [63:0] base, f_addr;
    int          err_total, tests_run;

    spcq_slow_path dut (
        .REF_CLK(ref_clk), .RESET(reset), .PAGE_BASE_WR(base_wr),
        .PAGE_BASE_DATA(base), .PROD_WR(prod_wr), .PROD_DATA(prod),
        .FETCH_REQ(f_req), .FETCH_ADDR(f_addr), .FETCH_VALID(f_valid),
        .FETCH_CMD(f_cmd), .FETCH_CID(f_cid), .CQE_VALID(cqe_valid),
        .CQE_CID(cqe_cid), .CQE_CMD(cqe_cmd), .CQE_SLOW_PATH(cqe_slow),
        .CQE_ERROR(cqe_err), .BD_CONSUME(bd), .SB_COMPLETION_IDX(sb),
        .PORT_READY(ready), .LEAD_LOCKED(locked), .PROC_INIT(proc_init),
        .CONS_IDX(cons), .LOAD_DONE(load_done), .MBOX_WR(mbox_wr),
        .MBOX_DATA(mbox_data), .MBOX_RESP_VALID(resp_valid),
        .MBOX_RESP(resp), .UNLOAD_KIND(unload), .MSI_VECTORS(msi),
        .MSIX_VECTORS(msix), .LINE_IRQ_SUPPORTED(line_irq)
    );

    spcq_host_mem host (
        .clk(ref_clk), .rst(reset), .req(f_req), .valid(f_valid),
        .cmd(f_cmd), .cid(f_cid), .cmd_in(h_cmd), .cid_in(h_cid), .lag(lag)
    );

    // ----
    // Helpers
    // ----
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t saw %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One command at a time, so never more than one queued
    task automatic run_cmd(input logic [3:0] c, input logic [15:0] id,
                           input logic [15:0] exp_cid, input logic err,
                           input logic to_sb);
        logic [7:0]  sb0;
        logic [15:0] slot;
        int          n;
        sb0 = sb;
        slot = cons;
        n = 0;
        @(posedge ref_clk);
        h_cmd <= c;
        h_cid <= id;
        lag <= c[1:0] ^ prod[1:0];
        prod <= (prod + 16'h1) % 16'(spcq_pkg::SLOTS);
        prod_wr <= 1'b1;
        @(posedge ref_clk);
        prod_wr <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1 n++;
            if (f_req === 1'b1)
                check(f_addr, base + 64'(slot) * 64'h40);
        end while (cqe_valid !== 1'b1 && sb === sb0 && n < 40);
        if (n == 40) begin
            err_total++;
            wrap_up();
        end
        check(cons, (slot + 16'h1) % 16'(spcq_pkg::SLOTS));
        if (to_sb) begin
            check({cqe_valid, sb}, {1'b0, sb0 + 8'h1});
        end else begin
            check({cqe_slow, bd, cqe_err, cqe_cid},
                  {2'b10, err, exp_cid});
            if (!err)
                check(cqe_cmd, c);
        end
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_mbox;
        for (int k = 1; k < 4; k++) begin
            @(posedge ref_clk);
            unload <= 2'(k);
            mbox_data <= {16'h0a5c, 16'(k)};
            mbox_wr <= 1'b1;
            @(posedge ref_clk);
            mbox_wr <= 1'b0;
            #1 check({resp_valid, resp},
                     {1'b1, 14'h0297, 2'(k), 16'(k)});
        end
    endtask

    task automatic t_bring_up;
        run_cmd(4'h1, 16'h0, 16'h0, 1'b1, 1'b0);
        run_cmd(4'h3, 16'h0, 16'h0, 1'b1, 1'b0);
        @(posedge ref_clk) load_done <= 1'b1;
        run_cmd(4'h1, 16'h0, 16'h0, 1'b0, 1'b0);
        check({ready, locked, proc_init}, 3'b111);
        run_cmd(4'h1, 16'h0, 16'h0, 1'b1, 1'b0);
    endtask

    task automatic t_commands;
        run_cmd(4'h2, 16'h3, 16'h3, 1'b0, 1'b0);
        run_cmd(4'h3, 16'h0, 16'h0, 1'b0, 1'b1);
        run_cmd(4'h4, 16'h0, 16'h0, 1'b0, 1'b0);
        run_cmd(4'h9, 16'h4, 16'h4, 1'b0, 1'b0);
        run_cmd(4'hf, 16'h0, 16'h0, 1'b1, 1'b0);
        for (int i = 0; i < 56; i++)
            run_cmd(4'h6, 16'h0, 16'h0, 1'b0, 1'b0);
        run_cmd(4'h5, 16'h0, 16'h0, 1'b1, 1'b0);
        run_cmd(4'h5, 16'h3, 16'h3, 1'b0, 1'b0);
        run_cmd(4'h7, 16'h3, 16'h0, 1'b0, 1'b0);
        run_cmd(4'h8, 16'h0, 16'h0, 1'b0, 1'b1);
        check({ready, locked}, 2'b00);
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        {reset, base_wr, prod_wr, load_done, mbox_wr} = 5'b10000;
        {unload, lag, h_cmd, h_cid, prod, mbox_data} = '0;
        base = 64'h0000_0002_4680_3000;
        err_total = 0;
        tests_run = 0;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1 check({cqe_valid, ready, sb, cons}, 26'h0);
        check({msi, msix, line_irq}, {5'h04, 5'h10, 1'b1});
        @(posedge ref_clk) base_wr <= 1'b1;
        @(posedge ref_clk) base_wr <= 1'b0;
        t_mbox();
        t_bring_up();
        t_commands();
        wrap_up();
    end
endmodule

`default_nettype wire
